// *** core/ibt_bit_timing.v ***
// Summary of operation
// - Every bit timing is a count of system clock cycles.
// - The 6-bit divider code maps to a decimal divider through a fixed table.
// - Codes 6h,7h,2Ah-2Dh give 768,896,960,1024,1280,1536.
// - As master, SCL stays low half the divider and high half the divider.
// - Start hold is divider/16 halved until below 16, or below 9 if bit 5 set.
// - A repeated start waits the full divider plus start hold first.
// - At least four clocks from qualified SCL high to a generated stop.
// - Inputs are delayed by twice the filter rate plus three clocks.
// - Filter latency adds on top of each timing that starts at a released SCL.
// - SCL and SDA are only pulled low, otherwise released to float high.
`timescale 1ns/1ps
`default_nettype none
`include "ibt_defs.vh"

module ibt_bit_timing #(
  parameter CODE_W = `IBT_CODE_W,
  parameter FSR_W = `IBT_FSR_W
) (
  input wire clock_in,
  input wire reset_in,
  input wire [CODE_W-1:0] divider_code_in,
  input wire [FSR_W-1:0] filter_sample_rate_in,
  input wire cmd_valid_in,
  input wire [1:0] cmd_op_in,
  input wire cmd_bit_in,
  output wire cmd_ready_out,
  output reg done_out,
  output reg rx_bit_out,
  output reg bus_owned_out,
  output reg [`IBT_DIV_W-1:0] decimal_divider_out,
  output wire scl_qual_out,
  output wire sda_qual_out,
  input wire scl_pin_in,
  input wire sda_pin_in,
  output wire scl_out,
  output reg scl_oe_n_out,
  output wire sda_out,
  output reg sda_oe_n_out
);

  localparam S_IDLE = 4'h0;
  localparam S_ST_HOLD = 4'h1;
  localparam S_BIT_LOW = 4'h2;
  localparam S_BIT_WAIT = 4'h3;
  localparam S_BIT_HIGH = 4'h4;
  localparam S_RS_LOW = 4'h5;
  localparam S_RS_WAIT = 4'h6;
  localparam S_RS_SETUP = 4'h7;
  localparam S_SP_LOW = 4'h8;
  localparam S_SP_WAIT = 4'h9;
  localparam S_SP_SETUP = 4'hA;

  ////////////////////////////////////////////////////////////////////////
  // Divider table, listed in code order.
  function [`IBT_DIV_W-1:0] decode_divider;
    input [5:0] code;
    begin
      case (code)
        6'h00: decode_divider = 16'd288;
        6'h01: decode_divider = 16'd320;
        6'h02: decode_divider = 16'd384;
        6'h03: decode_divider = 16'd448;
        6'h04: decode_divider = 16'd576;
        6'h05: decode_divider = 16'd640;
        6'h06: decode_divider = 16'd768;
        6'h07: decode_divider = 16'd896;
        6'h08: decode_divider = 16'd1152;
        6'h09: decode_divider = 16'd1280;
        6'h0A: decode_divider = 16'd1536;
        6'h0B: decode_divider = 16'd1792;
        6'h0C: decode_divider = 16'd2304;
        6'h0D: decode_divider = 16'd2560;
        6'h0E: decode_divider = 16'd3072;
        6'h0F: decode_divider = 16'd3584;
        6'h10: decode_divider = 16'd4608;
        6'h11: decode_divider = 16'd5120;
        6'h12: decode_divider = 16'd6144;
        6'h13: decode_divider = 16'd7168;
        6'h14: decode_divider = 16'd9216;
        6'h15: decode_divider = 16'd10240;
        6'h16: decode_divider = 16'd12288;
        6'h17: decode_divider = 16'd14336;
        6'h18: decode_divider = 16'd18432;
        6'h19: decode_divider = 16'd20480;
        6'h1A: decode_divider = 16'd24576;
        6'h1B: decode_divider = 16'd28672;
        6'h1C: decode_divider = 16'd36864;
        6'h1D: decode_divider = 16'd40960;
        6'h1E: decode_divider = 16'd49152;
        6'h1F: decode_divider = 16'd61440;
        6'h20: decode_divider = 16'd160;
        6'h21: decode_divider = 16'd192;
        6'h22: decode_divider = 16'd224;
        6'h23: decode_divider = 16'd256;
        6'h24: decode_divider = 16'd320;
        6'h25: decode_divider = 16'd384;
        6'h26: decode_divider = 16'd480;
        6'h27: decode_divider = 16'd512;
        6'h28: decode_divider = 16'd640;
        6'h29: decode_divider = 16'd768;
        6'h2A: decode_divider = 16'd960;
        6'h2B: decode_divider = 16'd1024;
        6'h2C: decode_divider = 16'd1280;
        6'h2D: decode_divider = 16'd1536;
        6'h2E: decode_divider = 16'd1920;
        6'h2F: decode_divider = 16'd2048;
        6'h30: decode_divider = 16'd2560;
        6'h31: decode_divider = 16'd3072;
        6'h32: decode_divider = 16'd3840;
        6'h33: decode_divider = 16'd4096;
        6'h34: decode_divider = 16'd5120;
        6'h35: decode_divider = 16'd6144;
        6'h36: decode_divider = 16'd7680;
        6'h37: decode_divider = 16'd8192;
        6'h38: decode_divider = 16'd10240;
        6'h39: decode_divider = 16'd12288;
        6'h3A: decode_divider = 16'd15360;
        6'h3B: decode_divider = 16'd16384;
        6'h3C: decode_divider = 16'd20480;
        6'h3D: decode_divider = 16'd24576;
        6'h3E: decode_divider = 16'd30720;
        6'h3F: decode_divider = 16'd32768;
        default: decode_divider = 16'd160;
      endcase
    end
  endfunction

  // The loop bound is the divider width, enough to bring any value below 9.
  function [`IBT_DIV_W-1:0] start_hold;
    input [`IBT_DIV_W-1:0] div;
    input hi;
    reg [`IBT_DIV_W-1:0] h;
    reg [`IBT_DIV_W-1:0] lim;
    integer i;
    begin
      h = div >> `IBT_HOLD_PRESCALE;
      lim = hi ? `IBT_HOLD_LIMIT_HI : `IBT_HOLD_LIMIT_LO;
      for (i = 0; i < `IBT_DIV_W; i = i + 1)
      begin
        if (h >= lim)
        begin
          h = h >> 1;
        end
      end
      start_hold = h;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  reg [3:0] state_reg;
  reg [`IBT_CNT_W-1:0] cnt_reg;
  reg [`IBT_DIV_W-1:0] hold_reg;
  reg bit_reg;
  wire [`IBT_CNT_W-1:0] half_cnt;
  wire [`IBT_CNT_W-1:0] rs_cnt;
  wire [`IBT_CNT_W-1:0] hold_cnt;
  wire [`IBT_CNT_W-1:0] sp_cnt;
  wire cnt_done;
  wire accept;
  wire [`IBT_CNT_W-1:0] wait_cnt;

  ibt_input_filter #(
    .FSR_W(FSR_W)
  ) u_filter (
    .clock_in(clock_in),
    .reset_in(reset_in),
    .filter_sample_rate_in(filter_sample_rate_in),
    .scl_pin_in(scl_pin_in),
    .sda_pin_in(sda_pin_in),
    .scl_qual_out(scl_qual_out),
    .sda_qual_out(sda_qual_out)
  );

  // Counters are loaded with length minus one and expire at zero.
  assign half_cnt = {2'b00, decimal_divider_out[`IBT_DIV_W-1:1]} - 17'h0_0001;
  assign hold_cnt = {1'b0, hold_reg} - 17'h0_0001;
  assign rs_cnt = {1'b0, decimal_divider_out} + {1'b0, hold_reg} - 17'h0_0001;
  // Stop setup is the longer of half a divider and the fixed least setup.
  assign sp_cnt = ((half_cnt + 17'h0_0001) > `IBT_STOP_SETUP_CLKS) ? half_cnt :
                  (`IBT_STOP_SETUP_CLKS - 17'h0_0001);
  // Each wait state is followed by its timed phase on the next state code.
  assign wait_cnt = (state_reg == S_RS_WAIT) ? rs_cnt :
                    (state_reg == S_SP_WAIT) ? sp_cnt : half_cnt;
  assign cnt_done = (cnt_reg == `IBT_RST_CNT);
  assign cmd_ready_out = (state_reg == S_IDLE);
  assign accept = cmd_valid_in && cmd_ready_out;
  // Only ever a low level is offered; the enables decide the pin.
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;

  always @(posedge clock_in)
  begin
    if (reset_in)
    begin
      decimal_divider_out <= `IBT_RST_DIV;
      hold_reg <= `IBT_RST_DIV;
    end
    else
    begin
      decimal_divider_out <= decode_divider(divider_code_in);
      hold_reg <= start_hold(decode_divider(divider_code_in), divider_code_in[`IBT_CODE_HI_BIT]);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Waits on the qualified clock let an outside device stretch the clock,
  // and make the filter latency part of every high period.
  always @(posedge clock_in)
  begin
    if (reset_in)
    begin
      state_reg <= S_IDLE;
      cnt_reg <= `IBT_RST_CNT;
      bit_reg <= 1'b1;
      done_out <= 1'b0;
      rx_bit_out <= 1'b0;
      bus_owned_out <= 1'b0;
      scl_oe_n_out <= 1'b1;
      sda_oe_n_out <= 1'b1;
    end
    else
    begin
      done_out <= 1'b0;
      if (!cnt_done)
      begin
        cnt_reg <= cnt_reg - 17'h0_0001;
      end
      case (state_reg)
        S_IDLE:
        begin
          if (accept)
          begin
            bit_reg <= cmd_bit_in;
            if (cmd_op_in == `IBT_OP_START && !bus_owned_out)
            begin
              sda_oe_n_out <= 1'b0;
              cnt_reg <= hold_cnt;
              state_reg <= S_ST_HOLD;
            end
            else if (cmd_op_in == `IBT_OP_START)
            begin
              scl_oe_n_out <= 1'b0;
              sda_oe_n_out <= 1'b1;
              cnt_reg <= half_cnt;
              state_reg <= S_RS_LOW;
            end
            else if (cmd_op_in == `IBT_OP_BIT)
            begin
              scl_oe_n_out <= 1'b0;
              sda_oe_n_out <= cmd_bit_in;
              cnt_reg <= half_cnt;
              state_reg <= S_BIT_LOW;
            end
            else if (cmd_op_in == `IBT_OP_STOP)
            begin
              scl_oe_n_out <= 1'b0;
              sda_oe_n_out <= 1'b0;
              cnt_reg <= half_cnt;
              state_reg <= S_SP_LOW;
            end
            else
            begin
              done_out <= 1'b1;
            end
          end
        end
        S_ST_HOLD:
        begin
          if (cnt_done)
          begin
            scl_oe_n_out <= 1'b0;
            bus_owned_out <= 1'b1;
            done_out <= 1'b1;
            state_reg <= S_IDLE;
          end
        end
        S_BIT_LOW, S_RS_LOW, S_SP_LOW:
        begin
          if (cnt_done)
          begin
            scl_oe_n_out <= 1'b1;
            state_reg <= state_reg + 4'h1;
          end
        end
        S_BIT_WAIT, S_RS_WAIT, S_SP_WAIT:
        begin
          if (scl_qual_out)
          begin
            cnt_reg <= wait_cnt;
            state_reg <= state_reg + 4'h1;
          end
        end
        S_BIT_HIGH:
        begin
          if (cnt_done)
          begin
            rx_bit_out <= sda_qual_out;
            scl_oe_n_out <= 1'b0;
            sda_oe_n_out <= bit_reg;
            done_out <= 1'b1;
            state_reg <= S_IDLE;
          end
        end
        S_RS_SETUP:
        begin
          if (cnt_done)
          begin
            sda_oe_n_out <= 1'b0;
            cnt_reg <= hold_cnt;
            state_reg <= S_ST_HOLD;
          end
        end
        S_SP_SETUP:
        begin
          if (cnt_done)
          begin
            sda_oe_n_out <= 1'b1;
            bus_owned_out <= 1'b0;
            done_out <= 1'b1;
            state_reg <= S_IDLE;
          end
        end
        default:
        begin
          state_reg <= S_IDLE;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// *** core/ibt_input_filter.v ***
`timescale 1ns/1ps
`default_nettype none
`include "ibt_defs.vh"

module ibt_input_filter #(
  parameter FSR_W = `IBT_FSR_W
) (
  input wire clock_in,
  input wire reset_in,
  input wire [FSR_W-1:0] filter_sample_rate_in,
  input wire scl_pin_in,
  input wire sda_pin_in,
  output reg scl_qual_out,
  output reg sda_qual_out
);

  localparam DEPTH = 2 * (1 << FSR_W);

  reg [1:0] scl_sync_reg;
  reg [1:0] sda_sync_reg;
  reg [DEPTH-1:0] scl_line_reg;
  reg [DEPTH-1:0] sda_line_reg;
  wire [FSR_W:0] tap;
  wire [DEPTH:0] scl_taps;
  wire [DEPTH:0] sda_taps;

  ////////////////////////////////////////////////////////////////////////
  // Tap zero is the synchroniser output itself, so the qualified line trails
  // it by twice the rate plus one; the two synchroniser cycles come on top.
  assign tap = {filter_sample_rate_in, 1'b0};
  assign scl_taps = {scl_line_reg, scl_sync_reg[1]};
  assign sda_taps = {sda_line_reg, sda_sync_reg[1]};

  always @(posedge clock_in)
  begin
    if (reset_in)
    begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
      scl_line_reg <= {DEPTH{1'b1}};
      sda_line_reg <= {DEPTH{1'b1}};
      scl_qual_out <= 1'b1;
      sda_qual_out <= 1'b1;
    end
    else
    begin
      scl_sync_reg <= {scl_sync_reg[0], scl_pin_in};
      sda_sync_reg <= {sda_sync_reg[0], sda_pin_in};
      scl_line_reg <= {scl_line_reg[DEPTH-2:0], scl_sync_reg[1]};
      sda_line_reg <= {sda_line_reg[DEPTH-2:0], sda_sync_reg[1]};
      scl_qual_out <= scl_taps[tap];
      sda_qual_out <= sda_taps[tap];
    end
  end

endmodule
`default_nettype wire

// *** inc/ibt_defs.vh ***
`ifndef IBT_DEFS_VH
`define IBT_DEFS_VH

// Widths of the configuration inputs, the divider and the counters.
`define IBT_CODE_W 6
`define IBT_FSR_W 6
`define IBT_DIV_W 16
`define IBT_CNT_W 17

// Command operations presented on cmd_op_in.
`define IBT_OP_START 2'h0
`define IBT_OP_BIT 2'h1
`define IBT_OP_STOP 2'h2

// Divider code bit that selects the start hold limit.
`define IBT_CODE_HI_BIT 5
// Start hold time is the divider shifted right by this, then halved until below a limit.
`define IBT_HOLD_PRESCALE 4
`define IBT_HOLD_LIMIT_LO 16'h0010
`define IBT_HOLD_LIMIT_HI 16'h0009

// Least setup from qualified clock high to a stop, in system clocks.
`define IBT_STOP_SETUP_CLKS 17'h0_0004

// Reset values.
`define IBT_RST_CNT 17'h0_0000
`define IBT_RST_DIV 16'h0000

`endif

// *** test/ibt_bit_timing_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "ibt_defs.vh"
module ibt_bit_timing_chk #(
  parameter CODE_W = 6,
  parameter FSR_W = 6
) (
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic [CODE_W-1:0] divider_code_in,
  input wire logic [FSR_W-1:0] filter_sample_rate_in,
  input wire logic cmd_valid_in,
  input wire logic [1:0] cmd_op_in,
  input wire logic cmd_bit_in,
  input wire logic cmd_ready_out,
  input wire logic done_out,
  input wire logic rx_bit_out,
  input wire logic bus_owned_out,
  input wire logic [15:0] decimal_divider_out,
  input wire logic scl_qual_out,
  input wire logic sda_qual_out,
  input wire logic scl_pin_in,
  input wire logic sda_pin_in,
  input wire logic scl_out,
  input wire logic scl_oe_n_out,
  input wire logic sda_out,
  input wire logic sda_oe_n_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (reset_in);
  logic [16:0] low_cnt, high_cnt, hold_cnt, half_div, full_wait;
  logic hold_arm, sda_oe_n_prev;
  function automatic [15:0] hold_of(input [15:0] d, input hi);
    hold_of = d >> 4;
    while (hold_of >= (hi ? 16'h0009 : 16'h0010))
      hold_of = hold_of >> 1;
  endfunction
  function automatic [15:0] div_of(input [5:0] c);
    case (c)
      6'h00: div_of = 16'h0120;
      6'h06: div_of = 16'h0300;
      6'h07: div_of = 16'h0380;
      6'h1e: div_of = 16'hc000;
      6'h1f: div_of = 16'hf000;
      6'h20: div_of = 16'h00a0;
      6'h21: div_of = 16'h00c0;
      6'h2a: div_of = 16'h03c0;
      6'h2b: div_of = 16'h0400;
      6'h2c: div_of = 16'h0500;
      6'h2d: div_of = 16'h0600;
      default: div_of = 16'h0000;
    endcase
  endfunction
  ////////////////////////////////////////////////////////////////
  // Counters stand in for long repetitions, which the tools cannot unroll.
  assign half_div = {1'b0, decimal_divider_out} >> 1;
  assign full_wait = {1'b0, decimal_divider_out} +
                     {1'b0, hold_of(decimal_divider_out, divider_code_in[5])};
  always @(posedge clock_in)
  begin
    low_cnt <= (reset_in || scl_oe_n_out) ? 17'h0_0000 : low_cnt + 17'h0_0001;
    high_cnt <= (reset_in || !scl_oe_n_out) ? 17'h0_0000 : high_cnt + {16'h0000, scl_qual_out};
    hold_cnt <= (reset_in || !scl_oe_n_out || sda_oe_n_out) ? 17'h0_0000 : hold_cnt + 17'h0_0001;
    sda_oe_n_prev <= sda_oe_n_out;
    hold_arm <= (reset_in || !scl_oe_n_out) ? 1'b0 : (hold_arm || (!sda_oe_n_out && sda_oe_n_prev));
  end
  sequence start_edge_s;
    scl_oe_n_out && $fell(sda_oe_n_out);
  endsequence
  sequence stop_edge_s;
    scl_oe_n_out && $rose(sda_oe_n_out);
  endsequence
  ////////////////////////////////////////////////////////////////
  AST_RESET_IDLE: assert property (disable iff (1'b0) reset_in
    |=> scl_oe_n_out && sda_oe_n_out && !bus_owned_out)
    else $error("lines not released after reset");
  AST_PINS_LOW_ONLY: assert property (scl_out == 1'b0 && sda_out == 1'b0)
    else $error("pin drives a high level");
  AST_DONE_PULSE: assert property (done_out && !(cmd_valid_in && cmd_op_in == 2'h3)
    |-> cmd_ready_out ##1 !done_out)
    else $error("done not a single pulse");
  AST_DIV_DECODE: assert property (!$past(reset_in) && div_of($past(divider_code_in)) != 16'h0000
    |-> decimal_divider_out == div_of($past(divider_code_in)))
    else $error("divider decode wrong");
  AST_SCL_LOW_MIN: assert property ($rose(scl_oe_n_out) |-> low_cnt >= half_div)
    else $error("clock low period short");
  AST_SCL_HIGH_MIN: assert property ($past(bus_owned_out) && $fell(scl_oe_n_out) |-> high_cnt >= half_div)
    else $error("clock high period short");
  AST_START_HOLD: assert property (hold_arm && $fell(scl_oe_n_out)
    |-> hold_cnt == {1'b0, hold_of(decimal_divider_out, divider_code_in[5])})
    else $error("start hold wrong");
  AST_RESTART_SETUP: assert property ($past(bus_owned_out) ##0 start_edge_s |-> high_cnt >= full_wait)
    else $error("repeated start setup short");
  AST_STOP_SETUP: assert property (stop_edge_s |-> high_cnt >= `IBT_STOP_SETUP_CLKS)
    else $error("stop setup short");
endmodule
`default_nettype wire

// *** test/ibt_bus_partner.sv ***
`timescale 1ns/1ps
`default_nettype none
module ibt_bus_partner (
  input wire logic clock_in,
  input wire logic scl_oe_n_in,
  input wire logic sda_oe_n_in,
  input wire logic [7:0] stretch_in,
  input wire logic sda_low_in,
  output logic scl_pin_out,
  output logic sda_pin_out
);
  logic [7:0] rel_cnt = 8'h00;
  // Stretching only holds a released clock low longer, so SCL never runs fast.
  always @(posedge clock_in)
    rel_cnt <= scl_oe_n_in ? rel_cnt + {7'h00, rel_cnt != 8'hff} : 8'h00;
  // Pull-ups: a line floats high unless some party pulls it low.
  assign scl_pin_out = scl_oe_n_in && (rel_cnt >= stretch_in);
  assign sda_pin_out = sda_oe_n_in && !sda_low_in;
endmodule
`default_nettype wire

// *** test/tb_i2c_bit_timing_divider.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "ibt_defs.vh"
module tb_i2c_bit_timing_divider;
  logic clock_in, reset_in, cmd_valid_in, cmd_bit_in, cmd_ready_out, done_out, rx_bit_out, bus_owned_out;
  logic scl_qual_out, sda_qual_out, scl_pin_in, sda_pin_in, scl_out, scl_oe_n_out, sda_out, sda_oe_n_out;
  logic [5:0] divider_code_in, filter_sample_rate_in;
  logic [1:0] cmd_op_in;
  logic [15:0] decimal_divider_out;
  logic [7:0] stretch;
  logic sda_low;
  int errors = 0, samples_checked = 0, cycles = 0;
  ibt_bit_timing dut (
    .clock_in(clock_in),
    .reset_in(reset_in),
    .divider_code_in(divider_code_in),
    .filter_sample_rate_in(filter_sample_rate_in),
    .cmd_valid_in(cmd_valid_in),
    .cmd_op_in(cmd_op_in),
    .cmd_bit_in(cmd_bit_in),
    .cmd_ready_out(cmd_ready_out),
    .done_out(done_out),
    .rx_bit_out(rx_bit_out),
    .bus_owned_out(bus_owned_out),
    .decimal_divider_out(decimal_divider_out),
    .scl_qual_out(scl_qual_out),
    .sda_qual_out(sda_qual_out),
    .scl_pin_in(scl_pin_in),
    .sda_pin_in(sda_pin_in),
    .scl_out(scl_out),
    .scl_oe_n_out(scl_oe_n_out),
    .sda_out(sda_out),
    .sda_oe_n_out(sda_oe_n_out)
  );
  ibt_bus_partner peer (.clock_in(clock_in), .scl_oe_n_in(scl_oe_n_out), .sda_oe_n_in(sda_oe_n_out),
    .stretch_in(stretch), .sda_low_in(sda_low), .scl_pin_out(scl_pin_in), .sda_pin_out(sda_pin_in));
  ////////////////////////////////////////////////////////////////
  task automatic tick();
    @(posedge clock_in);
    #1;
  endtask
  task automatic check(input logic [16:0] got, input logic [16:0] exp, input string what);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] %0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask
  task automatic complete_run();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Counts cycles with data low under a released clock: the start hold.
  task automatic send(input logic [1:0] op, input logic b, output int hold);
    int n;
    hold = 0;
    n = 0;
    while (cmd_ready_out !== 1'b1)
      tick();
    cmd_valid_in = 1'b1;
    cmd_op_in = op;
    cmd_bit_in = b;
    tick();
    cmd_valid_in = 1'b0;
    while (done_out !== 1'b1 && n < 20000)
    begin
      hold += (sda_oe_n_out === 1'b0 && scl_oe_n_out === 1'b1);
      n++;
      tick();
    end
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_decode();
    logic [5:0] codes [10] = '{6'h20, 6'h21, 6'h1e, 6'h1f, 6'h06, 6'h07, 6'h2a, 6'h2b, 6'h2c, 6'h2d};
    logic [15:0] divs [10] = '{16'h00a0, 16'h00c0, 16'hc000, 16'hf000, 16'h0300, 16'h0380, 16'h03c0,
      16'h0400, 16'h0500, 16'h0600};
    foreach (codes[i])
    begin
      divider_code_in = codes[i];
      tick();
      tick();
      check(decimal_divider_out, divs[i], "divider");
    end
  endtask
  task automatic t_filter();
    int n;
    sda_low = 1'b1;
    n = 0;
    while (sda_qual_out !== 1'b0 && n < 50)
    begin
      tick();
      n++;
    end
    check(n, 7, "filter delay");
    sda_low = 1'b0;
    repeat (10) tick();
  endtask
  // A no-op only answers with a done pulse on the edge that takes it.
  task automatic t_noop();
    int hold;
    int c0;
    c0 = cycles;
    send(2'h3, 1'b0, hold);
    check(cycles - c0, 1, "noop done");
    check(hold, 0, "noop lines");
    check(bus_owned_out, 0, "noop owned");
  endtask
  task automatic t_frame(input logic [5:0] code, input int h);
    int hold;
    divider_code_in = code;
    tick();
    tick();
    send(`IBT_OP_START, 1'b0, hold);
    check(hold, h, "start hold");
    check(bus_owned_out, 1, "owned");
    stretch = 8'h14;
    sda_low = 1'b1;
    send(`IBT_OP_BIT, 1'b1, hold);
    check(rx_bit_out, 0, "rx zero");
    sda_low = 1'b0;
    stretch = 8'h00;
    send(`IBT_OP_BIT, 1'b1, hold);
    check(rx_bit_out, 1, "rx one");
    send(`IBT_OP_START, 1'b0, hold);
    check(hold, h, "restart hold");
    send(`IBT_OP_BIT, 1'b0, hold);
    send(`IBT_OP_STOP, 1'b0, hold);
    check(bus_owned_out, 0, "released");
    check(sda_oe_n_out, 1, "sda free");
  endtask
  ////////////////////////////////////////////////////////////////
  initial
  begin
    clock_in = 1'b0;
    forever #12.5 clock_in = ~clock_in;
  end
  always @(posedge clock_in)
  begin
    cycles++;
    if (cycles > 40000)
    begin
      errors++;
      $display("[FAIL] %0t timeout", $time);
      complete_run();
    end
  end
  initial
  begin
    reset_in = 1'b1;
    cmd_valid_in = 1'b0;
    cmd_op_in = 2'h0;
    cmd_bit_in = 1'b0;
    divider_code_in = 6'h20;
    filter_sample_rate_in = 6'h02;
    stretch = 8'h00;
    sda_low = 1'b0;
    repeat (3) tick();
    reset_in = 1'b0;
    tick();
    tick();
    t_decode();
    t_filter();
    t_noop();
    t_frame(6'h20, 5);
    t_frame(6'h00, 9);
    t_frame(6'h06, 12);
    t_frame(6'h2a, 7);
    complete_run();
  end
endmodule
bind ibt_bit_timing ibt_bit_timing_chk #(.CODE_W(CODE_W), .FSR_W(FSR_W)) chk (
  .clock_in(clock_in),
  .reset_in(reset_in),
  .divider_code_in(divider_code_in),
  .filter_sample_rate_in(filter_sample_rate_in),
  .cmd_valid_in(cmd_valid_in),
  .cmd_op_in(cmd_op_in),
  .cmd_bit_in(cmd_bit_in),
  .cmd_ready_out(cmd_ready_out),
  .done_out(done_out),
  .rx_bit_out(rx_bit_out),
  .bus_owned_out(bus_owned_out),
  .decimal_divider_out(decimal_divider_out),
  .scl_qual_out(scl_qual_out),
  .sda_qual_out(sda_qual_out),
  .scl_pin_in(scl_pin_in),
  .sda_pin_in(sda_pin_in),
  .scl_out(scl_out),
  .scl_oe_n_out(scl_oe_n_out),
  .sda_out(sda_out),
  .sda_oe_n_out(sda_oe_n_out)
);
`default_nettype wire
